// ===== cmpe_pkg.sv
package cmpe_pkg;

  // Register addresses in the special register space
  localparam logic [7:0] CMPE_CTRL_ADDR = 8'h9A;
  localparam logic [7:0] CMPE_MODE_ADDR = 8'h9B;

  // Control register layout
  localparam int CMPE_ON_BIT    = 7;
  localparam int CMPE_LEVEL_BIT = 6;
  localparam int CMPE_RISE_BIT  = 5;
  localparam int CMPE_FALL_BIT  = 4;
  localparam int CMPE_POSH_LSB  = 2;
  localparam int CMPE_NEGH_LSB  = 0;

  // Mode register layout
  localparam int CMPE_ASYNC_BIT = 6;
  localparam int CMPE_RIE_BIT   = 5;
  localparam int CMPE_FIE_BIT   = 4;
  localparam int CMPE_RESP_LSB  = 0;

  localparam logic [7:0] CMPE_CTRL_RESET = 8'h00;
  localparam logic [7:0] CMPE_MODE_RESET = 8'h00;
  localparam logic [7:0] CMPE_ZERO_BYTE  = 8'h00;

  // Hysteresis codes, for both polarities
  typedef enum logic [1:0] {
    CMPE_HYST_OFF  = 2'h0,
    CMPE_HYST_5MV  = 2'h1,
    CMPE_HYST_10MV = 2'h2,
    CMPE_HYST_20MV = 2'h3
  } cmpe_hyst_t;

  // Response time, fastest to slowest
  typedef enum logic [1:0] {
    CMPE_RESP_0 = 2'h0,
    CMPE_RESP_1 = 2'h1,
    CMPE_RESP_2 = 2'h2,
    CMPE_RESP_3 = 2'h3
  } cmpe_resp_t;

  // Settings handed to the analog core
  typedef struct packed {
    logic       power_on;
    cmpe_hyst_t pos_hyst_sel;
    cmpe_hyst_t neg_hyst_sel;
    cmpe_resp_t resp_sel;
  } cmpe_analog_t;

  // Software visible control state
  typedef struct packed {
    logic       comparator_on;
    logic       rise_seen_flag;
    logic       fall_seen_flag;
    cmpe_hyst_t pos_hyst_sel;
    cmpe_hyst_t neg_hyst_sel;
  } cmpe_ctl_t;

  typedef struct packed {
    logic       pin_async;
    logic       rise_irq_unmask;
    logic       fall_irq_unmask;
    cmpe_resp_t resp_sel;
  } cmpe_mode_t;

endpackage

// ===== cmpe_ctrl.sv
`timescale 1ns/1ns
// How it works
// - Result readable, interruptible, and routable to pin.
// - Pin path async or clocked; async needs no clock.
// - Disabled: pin output low, comparator unpowered.
// - Software selects response time, speed versus current.
// - Positive and negative hysteresis set independently.
// - Positive hysteresis bits 3:2: off,5,10,20 mV.
// - Negative hysteresis: off, 5, 10, 20 mV.
// - Negative hysteresis bits 1:0, same code meaning.
// - Rising output transition sets flag bit 5.
// - Falling output transition sets flag bit 4.
// - Flags stay set until software writes zero.
// - Interrupt on rising, falling, or both edges.
// - Separate unmask bits for rise and fall.
// - Bit 6 reads present comparator output level.
// - Bit 7 switches comparator on and off.
// - Control at 0x9A, any page, resets zero.
module cmpe_ctrl (
  // Clock and reset
  input  wire logic                  MCLK,
  input  wire logic                  RESET,
  // Special register port
  input  wire logic [7:0]            SFR_ADDR,
  input  wire logic                  SFR_WR,
  input  wire logic                  SFR_RD,
  input  wire logic [7:0]            SFR_WDATA,
  output logic      [7:0]            SFR_RDATA,
  // Analog comparator core
  input  wire logic                  COMP_RAW,
  output cmpe_pkg::cmpe_analog_t     ANALOG_CFG,
  // Port pin and interrupt
  output logic                       PIN_OUT,
  output logic                       COMP_IRQ
);

  logic                 sync1_q, sync2_q, sync3_q;
  logic                 level_q;
  logic                 rise_evt, fall_evt, settled;
  logic                 ctrl_wr, mode_wr;
  cmpe_pkg::cmpe_ctl_t  ctl_q, ctl_d;
  cmpe_pkg::cmpe_mode_t mode_q, mode_d;
  logic                 pin_sync_q;

  // Raw comparator crosses into the clock domain through three stages
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      sync3_q <= 1'b0;
    end else begin
      sync1_q <= COMP_RAW;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  // A change counts only once the later two stages agree
  assign settled  = (sync2_q == sync3_q);
  assign rise_evt = settled && sync3_q && !level_q;
  assign fall_evt = settled && !sync3_q && level_q;

  always_ff @(posedge MCLK) begin
    if (RESET) begin
      level_q <= 1'b0;
    end else if (settled) begin
      level_q <= sync3_q;
    end
  end

  assign ctrl_wr = SFR_WR && (SFR_ADDR == cmpe_pkg::CMPE_CTRL_ADDR);
  assign mode_wr = SFR_WR && (SFR_ADDR == cmpe_pkg::CMPE_MODE_ADDR);

  // Control register; a hardware edge wins over a same-cycle clear
  always_comb begin
    ctl_d = ctl_q;
    if (ctrl_wr) begin
      ctl_d.comparator_on  = SFR_WDATA[cmpe_pkg::CMPE_ON_BIT];
      ctl_d.rise_seen_flag = SFR_WDATA[cmpe_pkg::CMPE_RISE_BIT];
      ctl_d.fall_seen_flag = SFR_WDATA[cmpe_pkg::CMPE_FALL_BIT];
      ctl_d.pos_hyst_sel   = cmpe_pkg::cmpe_hyst_t'(
        SFR_WDATA[cmpe_pkg::CMPE_POSH_LSB +: 2]);
      ctl_d.neg_hyst_sel   = cmpe_pkg::cmpe_hyst_t'(
        SFR_WDATA[cmpe_pkg::CMPE_NEGH_LSB +: 2]);
    end
    if (rise_evt) begin
      ctl_d.rise_seen_flag = 1'b1;
    end
    if (fall_evt) begin
      ctl_d.fall_seen_flag = 1'b1;
    end
  end

  always_ff @(posedge MCLK) begin
    if (RESET) begin
      // Struct leaves out the read-only level bit, so load field by field
      ctl_q.comparator_on  <=
        cmpe_pkg::CMPE_CTRL_RESET[cmpe_pkg::CMPE_ON_BIT];
      ctl_q.rise_seen_flag <=
        cmpe_pkg::CMPE_CTRL_RESET[cmpe_pkg::CMPE_RISE_BIT];
      ctl_q.fall_seen_flag <=
        cmpe_pkg::CMPE_CTRL_RESET[cmpe_pkg::CMPE_FALL_BIT];
      ctl_q.pos_hyst_sel   <= cmpe_pkg::cmpe_hyst_t'(
        cmpe_pkg::CMPE_CTRL_RESET[cmpe_pkg::CMPE_POSH_LSB +: 2]);
      ctl_q.neg_hyst_sel   <= cmpe_pkg::cmpe_hyst_t'(
        cmpe_pkg::CMPE_CTRL_RESET[cmpe_pkg::CMPE_NEGH_LSB +: 2]);
    end else begin
      ctl_q <= ctl_d;
    end
  end

  // Mode register: response time, unmask bits, pin path select
  always_comb begin
    mode_d = mode_q;
    if (mode_wr) begin
      mode_d.pin_async       = SFR_WDATA[cmpe_pkg::CMPE_ASYNC_BIT];
      mode_d.rise_irq_unmask = SFR_WDATA[cmpe_pkg::CMPE_RIE_BIT];
      mode_d.fall_irq_unmask = SFR_WDATA[cmpe_pkg::CMPE_FIE_BIT];
      mode_d.resp_sel        = cmpe_pkg::cmpe_resp_t'(
        SFR_WDATA[cmpe_pkg::CMPE_RESP_LSB +: 2]);
    end
  end

  always_ff @(posedge MCLK) begin
    if (RESET) begin
      mode_q.pin_async       <=
        cmpe_pkg::CMPE_MODE_RESET[cmpe_pkg::CMPE_ASYNC_BIT];
      mode_q.rise_irq_unmask <=
        cmpe_pkg::CMPE_MODE_RESET[cmpe_pkg::CMPE_RIE_BIT];
      mode_q.fall_irq_unmask <=
        cmpe_pkg::CMPE_MODE_RESET[cmpe_pkg::CMPE_FIE_BIT];
      mode_q.resp_sel        <= cmpe_pkg::cmpe_resp_t'(
        cmpe_pkg::CMPE_MODE_RESET[cmpe_pkg::CMPE_RESP_LSB +: 2]);
    end else begin
      mode_q <= mode_d;
    end
  end

  // Read data registered; unmapped addresses read zero
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      SFR_RDATA <= cmpe_pkg::CMPE_ZERO_BYTE;
    end else if (SFR_RD && SFR_ADDR == cmpe_pkg::CMPE_CTRL_ADDR) begin
      SFR_RDATA <= {ctl_q.comparator_on, level_q,
                    ctl_q.rise_seen_flag, ctl_q.fall_seen_flag,
                    ctl_q.pos_hyst_sel, ctl_q.neg_hyst_sel};
    end else if (SFR_RD && SFR_ADDR == cmpe_pkg::CMPE_MODE_ADDR) begin
      SFR_RDATA <= {1'b0, mode_q.pin_async, mode_q.rise_irq_unmask,
                    mode_q.fall_irq_unmask, 2'h0, mode_q.resp_sel};
    end else begin
      SFR_RDATA <= cmpe_pkg::CMPE_ZERO_BYTE;
    end
  end

  // Analog settings follow the registers; power drops when disabled
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      ANALOG_CFG <= '0;
    end else begin
      ANALOG_CFG.power_on     <= ctl_d.comparator_on;
      ANALOG_CFG.pos_hyst_sel <= ctl_d.pos_hyst_sel;
      ANALOG_CFG.neg_hyst_sel <= ctl_d.neg_hyst_sel;
      ANALOG_CFG.resp_sel     <= mode_d.resp_sel;
    end
  end

  // Interrupt level from flags and unmask bits
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      COMP_IRQ <= 1'b0;
    end else begin
      COMP_IRQ <= (ctl_d.rise_seen_flag && mode_d.rise_irq_unmask) ||
                  (ctl_d.fall_seen_flag && mode_d.fall_irq_unmask);
    end
  end

  // Clocked pin copy, low while disabled
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      pin_sync_q <= 1'b0;
    end else begin
      pin_sync_q <= level_q && ctl_q.comparator_on;
    end
  end

  // Async path bypasses the synchronizer and pin flops so it works with the clock stopped;
  // it is the one output not taken from a register
  assign PIN_OUT = mode_q.pin_async ?
                   (COMP_RAW && ctl_q.comparator_on) :
                   pin_sync_q;

endmodule // cmpe_ctrl

// ===== cmpe_monitor.sv
`timescale 1ns/1ns
module cmpe_monitor (
  // Clock, reset, register port
  input logic                   MCLK,
  input logic                   RESET,
  input logic [7:0]             SFR_ADDR,
  input logic                   SFR_WR,
  input logic                   SFR_RD,
  input logic [7:0]             SFR_WDATA,
  input logic [7:0]             SFR_RDATA,
  // Comparator side
  input logic                   COMP_RAW,
  input cmpe_pkg::cmpe_analog_t ANALOG_CFG,
  input logic                   PIN_OUT,
  input logic                   COMP_IRQ
);
  logic       wc, wm;
  logic [1:0] um_q;
  assign wc = SFR_WR && SFR_ADDR == 8'h9A;
  assign wm = SFR_WR && SFR_ADDR == 8'h9B;
  // Unmask copy, unmask bits are not at the ports
  always_ff @(posedge MCLK) begin
    if (RESET) um_q <= 2'h0;
    else if (wm) um_q <= SFR_WDATA[5:4];
  end
  default clocking @(posedge MCLK); endclocking
  default disable iff (RESET);
  cfg_write_a: assert property (wc |=>
    {ANALOG_CFG[6], 3'h0, ANALOG_CFG[5:2]} == ($past(SFR_WDATA) & 8'h8F))
    else $error("cfg write");
  resp_write_a: assert property (wm |=>
    {6'h00, ANALOG_CFG[1:0]} == ($past(SFR_WDATA) & 8'h03))
    else $error("resp write");
  cfg_hold_a: assert property (!wc && !wm |=> $stable(ANALOG_CFG))
    else $error("cfg moved");
  rd_ctrl_a: assert property ($past(SFR_RD) && !$past(SFR_WR) &&
    $past(SFR_ADDR) == 8'h9A |-> (SFR_RDATA & 8'h8F) ==
    {ANALOG_CFG[6], 3'h0, ANALOG_CFG[5:2]}) else $error("ctrl read");
  pin_off_a: assert property (!ANALOG_CFG[6] &&
    !$past(ANALOG_CFG[6]) |-> !PIN_OUT) else $error("pin on");
  irq_mask_a: assert property (COMP_IRQ |-> |um_q)
    else $error("irq masked");
  rise_irq_a: assert property ($rose(COMP_RAW) && um_q[1]
    ##1 (COMP_RAW && um_q[1] && !SFR_WR)[*3] |-> ##[0:1] COMP_IRQ)
    else $error("no rise irq");
  irq_hold_a: assert property (COMP_IRQ && !SFR_WR |=> COMP_IRQ)
    else $error("irq dropped");
  cover property (COMP_IRQ);
  cover property (wc);
  cover property (PIN_OUT);
endmodule // cmpe_monitor

// ===== cmpe_analog_model.sv
`timescale 1ns/1ns
// Response time and hysteresis not modelled
module cmpe_analog_model (
  // Settings and input condition
  input  cmpe_pkg::cmpe_analog_t cfg,
  input  logic                   above,
  // Core output
  output logic                   raw
);
  // Unpowered core reads low
  assign raw = cfg.power_on & above;
endmodule // cmpe_analog_model

// ===== testbench.sv
`timescale 1ns/1ns
module testbench;
  logic                   mclk = 1'b0, reset = 1'b1, wr = 1'b0, rd = 1'b0;
  logic                   above = 1'b0, raw, pin, irq;
  logic [7:0]             addr = 8'h00, wdata = 8'h00, rdata, d;
  cmpe_pkg::cmpe_analog_t cfg;
  int                     bad_count = 0, samples_checked = 0;
  always #20 mclk = ~mclk;
  cmpe_ctrl u_cmpe_ctrl (.MCLK(mclk), .RESET(reset), .SFR_ADDR(addr),
    .SFR_WR(wr), .SFR_RD(rd), .SFR_WDATA(wdata), .SFR_RDATA(rdata),
    .COMP_RAW(raw), .ANALOG_CFG(cfg), .PIN_OUT(pin), .COMP_IRQ(irq));
  cmpe_analog_model u_cmpe_analog_model (.cfg(cfg), .above(above), .raw(raw));
  task automatic summarize();
    $display("Checked %0d, bad %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
    @(negedge mclk);
    addr = a;
    wdata = v;
    wr = 1'b1;
    @(negedge mclk);
    wr = 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(negedge mclk);
    addr = a;
    rd = 1'b1;
    @(negedge mclk);
    rd = 1'b0;
    chk(rdata, exp);
  endtask
  // Level bit is read-only, written value ignored
  function automatic logic [7:0] ctrl_exp(input logic [7:0] v, input logic l);
    return {v[7], l, v[5:0]};
  endfunction
  initial begin
    d = 8'($urandom(32'h1B3DBE9D));
    repeat (20) @(negedge mclk);
    reset = 1'b0;
    rd_chk(8'h9A, 8'h00);
    // Positive code i, negative code 3-i, response i
    for (int i = 0; i < 4; i++) begin
      wr_reg(8'h9A, 8'(8'h83 + 3 * i));
      wr_reg(8'h9B, 8'(i));
      chk({1'b0, cfg}, 8'(8'h4C + 13 * i));
    end
    repeat (8) begin
      d = 8'($urandom);
      wr_reg(8'h9A, d);
      rd_chk(8'h9A, ctrl_exp(d, 1'b0));
      wr_reg(8'h9B, ~d);
      rd_chk(8'h9B, ~d & 8'h73);
    end
    wr_reg(8'h5C, d);
    rd_chk(8'h5C, 8'h00);
    wr_reg(8'h9A, 8'h80);
    wr_reg(8'h9B, 8'h20);
    above = 1'b1;
    repeat (5) @(negedge mclk);
    chk({7'h00, irq}, 8'h01);
    rd_chk(8'h9A, 8'hE0);
    chk({7'h00, pin}, 8'h01);
    above = 1'b0;
    repeat (6) @(negedge mclk);
    rd_chk(8'h9A, 8'hB0);
    chk({7'h00, irq}, 8'h01);
    wr_reg(8'h9A, 8'h80);
    chk({7'h00, irq}, 8'h00);
    wr_reg(8'h9B, 8'h50);
    above = 1'b1;
    #1 chk({7'h00, pin}, 8'h01);
    repeat (6) @(negedge mclk);
    chk({7'h00, irq}, 8'h00);
    above = 1'b0;
    repeat (5) @(negedge mclk);
    chk({7'h00, irq}, 8'h01);
    wr_reg(8'h9A, 8'h00);
    above = 1'b1;
    #1 chk({7'h00, pin}, 8'h00);
    summarize();
  end
endmodule // testbench
bind cmpe_ctrl cmpe_monitor u_cmpe_monitor (.MCLK(MCLK), .RESET(RESET),
  .SFR_ADDR(SFR_ADDR), .SFR_WR(SFR_WR), .SFR_RD(SFR_RD),
  .SFR_WDATA(SFR_WDATA), .SFR_RDATA(SFR_RDATA), .COMP_RAW(COMP_RAW),
  .ANALOG_CFG(ANALOG_CFG), .PIN_OUT(PIN_OUT), .COMP_IRQ(COMP_IRQ));
